// ===== hw/speed_setpoint_source.sv
// Purpose: speed setpoint source selection and ramped up/down setpoint
// Assumes: APB slave, zero wait states, speeds in signed rpm
// Notes:   ramp step paced by a millisecond tick, at most one rpm per clock
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module speed_setpoint_source #(
  parameter int TICK_CYCLES = setpoint_pkg::TICK_CYCLES_DFLT,
  parameter int PZD_WORDS   = 2
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // setpoint sources
  input  wire setpoint_pkg::speed_t         analog_ch0,
  input  wire logic [PZD_WORDS-1:0][15:0]   pzd_rx,
  input  wire setpoint_pkg::speed_t         fixed_setpoint,
  input  wire setpoint_pkg::override_in_t   override_in,
  // drive state and binary pins
  input  wire logic                         motor_on,
  input  wire logic [setpoint_pkg::BIN_N-1:0] bin_in,
  // non-volatile store
  input  wire setpoint_pkg::speed_t         nv_restore,
  output setpoint_pkg::nv_out_t             nv_out,
  // results
  output setpoint_pkg::speed_t              main_setpoint,
  output setpoint_pkg::speed_t              supp_setpoint,
  output setpoint_pkg::speed_t              updown_output_after_ramp,
  output logic                              override_active
);
  import setpoint_pkg::*;

  // ************************************************
  // helpers
  // ************************************************
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  function automatic logic bin_pick(input logic [2:0]       idx,
                                    input logic [BIN_N-1:0] v);
    logic [2:0] k;
    k = 3'(idx - 3'h1);
    return (idx == 3'h0) ? 1'b0 : v[k];
  endfunction : bin_pick

  function automatic speed_t src_pick(input src_sel_t sel,
                                      input speed_t   an,
                                      input speed_t   fb,
                                      input speed_t   ud,
                                      input speed_t   fx);
    speed_t r;
    case (sel)
      SRC_ANALOG:   r = an;
      SRC_FIELDBUS: r = fb;
      SRC_UPDOWN:   r = ud;
      SRC_FIXED:    r = fx;
      default:      r = an;
    endcase
    return r;
  endfunction : src_pick

  function automatic speed_t clamp(input speed_t v,
                                   input speed_t lo,
                                   input speed_t hi);
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : clamp

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_STATUS);
  endfunction : mapped

  // ************************************************
  // decoded signals
  // ************************************************
  state_t          s;
  state_t          next_s;
  speed_t          fb_word;
  logic            raise;
  logic            lower;
  logic            inv;
  logic            auto_mode;
  logic            accept;
  logic            up;
  logic            dn;
  logic            run;
  logic            ramp_on;
  logic            tick;
  speed_t          hi_raw;
  speed_t          lo_raw;
  speed_t          hi;
  speed_t          lo;
  logic [16:0]     hi_abs;
  logic [16:0]     lo_abs;
  logic [16:0]     span;
  logic [15:0]     t_sel;
  speed_t          preset;
  speed_t          main_raw;
  logic            wr;
  logic            setup;

  assign fb_word   = speed_t'(pzd_rx[PZD_SPEED_IDX]);
  assign raise     = bin_pick(s.srcs.raise_command_source, s.sync2);
  assign lower     = bin_pick(s.srcs.lower_command_source, s.sync2);
  assign inv       = bin_pick(s.srcs.limit_invert_source, s.sync2);
  assign auto_mode = bin_pick(s.srcs.manual_auto_select_source, s.sync2);
  assign accept    = bin_pick(s.srcs.accept_preset_source, s.sync2);
  assign up        = raise & ~lower;
  assign dn        = lower & ~raise;
  assign run       = motor_on | s.updown_config_bits[CFG_ALWAYS];
  assign ramp_on   = ~auto_mode | s.updown_config_bits[CFG_RAMP];
  assign tick      = (s.tick_cnt == TICK_LAST);
  assign t_sel     = up ? s.updown_ramp_up_time : s.updown_ramp_down_time;

  // limits, sign flipped while inverting, then ordered
  assign hi_raw = inv ? speed_t'(-s.updown_min_speed) : s.updown_max_speed;
  assign lo_raw = inv ? speed_t'(-s.updown_max_speed) : s.updown_min_speed;
  assign hi     = (hi_raw >= lo_raw) ? hi_raw : lo_raw;
  assign lo     = (hi_raw >= lo_raw) ? lo_raw : hi_raw;
  assign hi_abs = hi[SPD_W-1] ? 17'(-{hi[SPD_W-1], hi}) : {1'b0, hi};
  assign lo_abs = lo[SPD_W-1] ? 17'(-{lo[SPD_W-1], lo}) : {1'b0, lo};
  assign span   = (hi_abs >= lo_abs) ? hi_abs : lo_abs;

  always_comb begin
    case (s.srcs.preset_value_source)
      PRE_ZERO:     preset = '0;
      PRE_ANALOG:   preset = analog_ch0;
      PRE_FIELDBUS: preset = fb_word;
      default:      preset = fixed_setpoint;
    endcase
  end

  assign main_raw = src_pick(s.main_setpoint_select, analog_ch0, fb_word,
                             s.out, fixed_setpoint);
  assign setup    = psel & ~penable;
  assign wr       = psel & penable & pwrite;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    logic [31:0] add;
    logic [31:0] t32;
    add    = '0;
    t32    = {16'h0, t_sel};
    next_s = s;

    // pin synchroniser
    next_s.sync1 = bin_in;
    next_s.sync2 = s.sync1;
    next_s.motor_q  = motor_on;
    next_s.accept_q = accept;
    next_s.nv.write = 1'b0;
    next_s.tick_cnt = tick ? '0 : TICK_W'(s.tick_cnt + 1'b1);

    // register writes take effect on the access edge
    if (wr) begin
      case (paddr)
        OFS_CFG:      next_s.updown_config_bits = pwdata[4:0];
        OFS_MAIN_SEL: next_s.main_setpoint_select = src_sel_t'(pwdata[1:0]);
        OFS_SUPP_SEL: next_s.supplementary_setpoint_select = src_sel_t'(pwdata[1:0]);
        OFS_MAX:      next_s.updown_max_speed = speed_t'(pwdata[15:0]);
        OFS_MIN:      next_s.updown_min_speed = speed_t'(pwdata[15:0]);
        OFS_START:    next_s.updown_start_value = speed_t'(pwdata[15:0]);
        OFS_UP_T:     next_s.updown_ramp_up_time = pwdata[15:0];
        OFS_DN_T:     next_s.updown_ramp_down_time = pwdata[15:0];
        OFS_SRC:      next_s.srcs = src_cfg_t'(pwdata[16:0]);
        default:      next_s.srcs = s.srcs;
      endcase
    end

    // ramped up/down counter
    if (run && (up || dn)) begin
      if (!ramp_on || t_sel == 16'h0) begin
        next_s.out  = up ? hi : lo;
        next_s.frac = '0;
      end else begin
        if (tick) begin
          add = (s.updown_config_bits[CFG_ROUND] && s.round_cnt < ROUND_MS)
              ? 32'(span >> 2) : 32'(span);
          if (s.round_cnt != 8'hff) begin
            next_s.round_cnt = 8'(s.round_cnt + 1'b1);
          end
        end
        if ((up && s.out >= hi) || (dn && s.out <= lo)) begin
          next_s.frac = '0;
        end else if (s.frac >= t32) begin
          next_s.out  = up ? speed_t'(s.out + 1'b1) : speed_t'(s.out - 1'b1);
          next_s.frac = s.frac - t32 + add;
        end else begin
          next_s.frac = s.frac + add;
        end
      end
    end else begin
      next_s.frac      = '0;
      next_s.round_cnt = '0;
    end

    // switch-on restart and switch-off save
    if (motor_on && !s.motor_q) begin
      next_s.out = s.updown_config_bits[CFG_STORE] ? s.stored
                                                   : s.updown_start_value;
    end
    if (!motor_on && s.motor_q && s.updown_config_bits[CFG_STORE]) begin
      next_s.stored   = s.out;
      next_s.nv.value = s.out;
      next_s.nv.write = s.updown_config_bits[CFG_NV];
    end
    if (!s.booted) begin
      next_s.booted = 1'b1;
      next_s.stored = nv_restore;
    end

    // preset load on accept edge
    if (accept && !s.accept_q) begin
      next_s.out = preset;
    end
    next_s.out = clamp(next_s.out, lo, hi);

    // setpoint routing with override priority panel, jog, technology
    next_s.ovr = override_in.panel_on | override_in.jog_on | override_in.tech_on;
    if (override_in.panel_on) begin
      next_s.main_sp = override_in.panel_sp;
    end else if (override_in.jog_on) begin
      next_s.main_sp = override_in.jog_sp;
    end else if (override_in.tech_on) begin
      next_s.main_sp = override_in.tech_sp;
    end else begin
      next_s.main_sp = main_raw;
    end
    next_s.supp_sp = src_pick(s.supplementary_setpoint_select, analog_ch0,
                              fb_word, s.out, fixed_setpoint);

    // read data captured in the setup phase
    if (setup) begin
      case (paddr)
        OFS_CFG:      next_s.prdata = {27'h0, s.updown_config_bits};
        OFS_MAIN_SEL: next_s.prdata = {30'h0, s.main_setpoint_select};
        OFS_SUPP_SEL: next_s.prdata = {30'h0, s.supplementary_setpoint_select};
        OFS_MAX:      next_s.prdata = {16'h0, s.updown_max_speed};
        OFS_MIN:      next_s.prdata = {16'h0, s.updown_min_speed};
        OFS_START:    next_s.prdata = {16'h0, s.updown_start_value};
        OFS_UP_T:     next_s.prdata = {16'h0, s.updown_ramp_up_time};
        OFS_DN_T:     next_s.prdata = {16'h0, s.updown_ramp_down_time};
        OFS_SRC:      next_s.prdata = {15'h0, s.srcs};
        OFS_OUT:      next_s.prdata = {16'h0, s.out};
        OFS_MAIN_OUT: next_s.prdata = {16'h0, s.main_sp};
        OFS_SUPP_OUT: next_s.prdata = {16'h0, s.supp_sp};
        OFS_STATUS:   next_s.prdata = {26'h0, up, dn, inv, auto_mode,
                                       s.ovr, s.motor_q};
        default:      next_s.prdata = '0;
      endcase
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.updown_config_bits    <= CFG_RST;
      s.main_setpoint_select  <= SRC_ANALOG;
      s.supplementary_setpoint_select <= SRC_ANALOG;
      s.updown_ramp_up_time   <= RAMP_TIME_MS_RST;
      s.updown_ramp_down_time <= RAMP_TIME_MS_RST;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign prdata                   = s.prdata;
  assign pready                   = 1'b1;
  assign pslverr                  = psel & penable & ~mapped(paddr);
  assign nv_out                   = s.nv;
  assign main_setpoint            = s.main_sp;
  assign supp_setpoint            = s.supp_sp;
  assign updown_output_after_ramp = s.out;
  assign override_active          = s.ovr;

endmodule : speed_setpoint_source

// ===== shared/setpoint_pkg.sv
// Purpose: shared types and constants of the speed setpoint front end
// Assumes: 250 MHz control clock, speeds as signed 16-bit rpm
// Notes:   register offsets are byte addresses on a 32-bit APB
package setpoint_pkg;

  // ************************************************
  // widths and timing
  // ************************************************
  localparam int SPD_W        = 16;
  localparam int BIN_N        = 7;
  localparam int TICK_W       = 20;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TICK_NS      = 1000000;
  localparam int TICK_CYCLES_DFLT = (TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int RAMP_TIME_S  = 10;
  localparam logic [15:0] RAMP_TIME_MS_RST = 16'(RAMP_TIME_S * 1000);
  localparam logic [7:0]  ROUND_MS = 8'h32;
  localparam int PZD_SPEED_IDX = 1;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_MAIN_SEL = 8'h04;
  localparam logic [7:0] OFS_SUPP_SEL = 8'h08;
  localparam logic [7:0] OFS_MAX      = 8'h0c;
  localparam logic [7:0] OFS_MIN      = 8'h10;
  localparam logic [7:0] OFS_START    = 8'h14;
  localparam logic [7:0] OFS_UP_T     = 8'h18;
  localparam logic [7:0] OFS_DN_T     = 8'h1c;
  localparam logic [7:0] OFS_SRC      = 8'h20;
  localparam logic [7:0] OFS_OUT      = 8'h24;
  localparam logic [7:0] OFS_MAIN_OUT = 8'h28;
  localparam logic [7:0] OFS_SUPP_OUT = 8'h2c;
  localparam logic [7:0] OFS_STATUS   = 8'h30;

  localparam int CFG_STORE  = 0;
  localparam int CFG_RAMP   = 1;
  localparam int CFG_ROUND  = 2;
  localparam int CFG_NV     = 3;
  localparam int CFG_ALWAYS = 4;
  localparam logic [4:0] CFG_RST = 5'h06;

  localparam logic [1:0] PRE_ZERO     = 2'h0;
  localparam logic [1:0] PRE_ANALOG   = 2'h1;
  localparam logic [1:0] PRE_FIELDBUS = 2'h2;

  // ************************************************
  // types
  // ************************************************
  typedef logic signed [SPD_W-1:0] speed_t;

  typedef enum logic [1:0] {
    SRC_ANALOG,
    SRC_FIELDBUS,
    SRC_UPDOWN,
    SRC_FIXED
  } src_sel_t;

  typedef struct packed {
    logic [1:0] preset_value_source;
    logic [2:0] accept_preset_source;
    logic [2:0] manual_auto_select_source;
    logic [2:0] limit_invert_source;
    logic [2:0] lower_command_source;
    logic [2:0] raise_command_source;
  } src_cfg_t;

  typedef struct packed {
    logic   tech_on;
    speed_t tech_sp;
    logic   jog_on;
    speed_t jog_sp;
    logic   panel_on;
    speed_t panel_sp;
  } override_in_t;

  typedef struct packed {
    logic   write;
    speed_t value;
  } nv_out_t;

  typedef struct packed {
    logic [4:0]        updown_config_bits;
    src_sel_t          main_setpoint_select;
    src_sel_t          supplementary_setpoint_select;
    speed_t            updown_max_speed;
    speed_t            updown_min_speed;
    speed_t            updown_start_value;
    logic [15:0]       updown_ramp_up_time;
    logic [15:0]       updown_ramp_down_time;
    src_cfg_t          srcs;
    speed_t            out;
    logic [31:0]       frac;
    logic [TICK_W-1:0] tick_cnt;
    logic [7:0]        round_cnt;
    speed_t            stored;
    logic [BIN_N-1:0]  sync1;
    logic [BIN_N-1:0]  sync2;
    logic              motor_q;
    logic              accept_q;
    logic              booted;
    nv_out_t           nv;
    logic [31:0]       prdata;
    speed_t            main_sp;
    speed_t            supp_sp;
    logic              ovr;
  } state_t;

endpackage : setpoint_pkg

// ===== sim/fieldbus_partner.sv
// Purpose: far side model, bus master words and local pins
// Assumes: word 1 carries the speed
// Notes:   other words change every cycle
`timescale 1ns/1ps
module fieldbus_partner #(
  parameter int PZD_WORDS = 2
) (
  // clock
  input  wire logic                             pclk,
  // bench requests
  input  wire setpoint_pkg::speed_t             speed,
  input  wire logic [setpoint_pkg::BIN_N-1:0]   pins,
  // towards the block
  output logic      [PZD_WORDS-1:0][15:0]       pzd_rx,
  output logic      [setpoint_pkg::BIN_N-1:0]   bin_in
);
  import setpoint_pkg::*;
  logic [15:0] ctl_word = 16'h0000;
  always @(posedge pclk) ctl_word <= ~ctl_word;
  always_comb begin
    pzd_rx = {PZD_WORDS{ctl_word}};
    pzd_rx[PZD_SPEED_IDX] = speed;
  end
  assign bin_in = pins;
endmodule : fieldbus_partner

// ===== sim/setpoint_sva.sv
// Purpose: port checker of the setpoint front end
// Assumes: selects and limits are followed from apb writes
// Notes:   bound into the design below
`timescale 1ns/1ps
module setpoint_sva #(
  parameter int PZD_WORDS = 2
) (
  // clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // apb
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic [31:0]                pwdata,
  input wire logic                       pslverr,
  // sources and results
  input wire setpoint_pkg::speed_t       analog_ch0,
  input wire logic [PZD_WORDS-1:0][15:0] pzd_rx,
  input wire setpoint_pkg::override_in_t override_in,
  input wire setpoint_pkg::nv_out_t      nv_out,
  input wire setpoint_pkg::speed_t       main_setpoint,
  input wire setpoint_pkg::speed_t       supp_setpoint,
  input wire setpoint_pkg::speed_t       updown_output_after_ramp,
  input wire logic                       override_active
);
  import setpoint_pkg::*;
  // ****************
  // shadow of selects
  // ****************
  logic [1:0] msel;
  logic [1:0] ssel;
  logic       lim_set;
  logic       ovr;
  assign ovr = override_in.tech_on || override_in.jog_on || override_in.panel_on;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msel    <= 2'h0;
      ssel    <= 2'h0;
      lim_set <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == OFS_MAIN_SEL) msel <= pwdata[1:0];
      if (paddr == OFS_SUPP_SEL) ssel <= pwdata[1:0];
      if (paddr == OFS_MAX || paddr == OFS_MIN) lim_set <= 1'b1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // assertions
  // ****************
  ovr_panel_a: assert property (override_in.panel_on
    |=> main_setpoint == $past(override_in.panel_sp)) else $error("panel override lost");
  ovr_jog_a: assert property (override_in.jog_on && !override_in.panel_on
    |=> main_setpoint == $past(override_in.jog_sp)) else $error("jog override lost");
  ovr_flag_a: assert property (1'b1 |=> override_active == $past(ovr))
    else $error("override flag wrong");
  main_analog_a: assert property (!ovr && msel == 2'h0
    |=> main_setpoint == $past(analog_ch0)) else $error("main analog wrong");
  main_bus_a: assert property (!ovr && msel == 2'h1
    |=> main_setpoint == speed_t'($past(pzd_rx[PZD_SPEED_IDX]))) else $error("main bus wrong");
  main_updown_a: assert property (!ovr && msel == 2'h2
    |=> main_setpoint == $past(updown_output_after_ramp)) else $error("main updown wrong");
  supp_bus_a: assert property (!ovr && ssel == 2'h1
    |=> supp_setpoint == speed_t'($past(pzd_rx[PZD_SPEED_IDX]))) else $error("supp bus wrong");
  lim_zero_a: assert property (!lim_set |-> updown_output_after_ramp == '0)
    else $error("output off zero limits");
  nv_pulse_a: assert property (nv_out.write |=> !nv_out.write)
    else $error("store pulse too long");
  err_phase_a: assert property (pslverr |-> psel && penable
    && (paddr > 8'h30 || paddr[1:0] != 2'h0)) else $error("error outside bad access");
  cover property (override_in.panel_on);
  cover property (nv_out.write);
  cover property (pslverr);
endmodule : setpoint_sva

bind speed_setpoint_source setpoint_sva #(.PZD_WORDS(PZD_WORDS)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .analog_ch0(analog_ch0), .pzd_rx(pzd_rx), .override_in(override_in),
  .nv_out(nv_out), .main_setpoint(main_setpoint), .supp_setpoint(supp_setpoint),
  .updown_output_after_ramp(updown_output_after_ramp),
  .override_active(override_active));

// ===== sim/testbench.sv
// Purpose: self-checking bench of the setpoint front end
// Assumes: short tick of 4 clocks
// Notes:   pins: 0 raise, 1 lower, 2 invert, 3 auto, 4 accept
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module testbench;
  import setpoint_pkg::*;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  speed_t              analog_ch0 = 16'hfffb;
  speed_t              fixed_setpoint = 16'h0456;
  speed_t              bus_speed = 16'h0123;
  override_in_t        override_in = '0;
  logic                motor_on = 1'b0;
  logic [BIN_N-1:0]    pins = '0;
  logic [BIN_N-1:0]    bin_in;
  logic [1:0][15:0]    pzd_rx;
  nv_out_t             nv_out;
  speed_t              main_sp;
  speed_t              supp_sp;
  speed_t              ud;
  logic                ovr_act;
  speed_t              nv_val = 16'h0;
  int                  nv_cnt = 0;
  int                  error_cnt = 0;
  int                  n_tests = 0;
  logic [7:0]          ra[7] = '{OFS_CFG, OFS_UP_T, OFS_DN_T, OFS_MAX, OFS_MIN, OFS_START,
                                 OFS_MAIN_SEL};
  logic [31:0]         rv[7] = '{32'h6, 32'h2710, 32'h2710, 32'h0, 32'h0, 32'h0, 32'h0};
  speed_t              ex[4] = '{16'hfffb, 16'h0123, 16'h0000, 16'h0456};
  speed_t              ovx[4] = '{16'hfffb, 16'h0111, 16'h0222, 16'h0333};
  always #2 pclk = ~pclk;
  speed_setpoint_source #(.TICK_CYCLES(4), .PZD_WORDS(2)) i_speed_setpoint_source (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_ch0(analog_ch0), .pzd_rx(pzd_rx), .fixed_setpoint(fixed_setpoint),
    .override_in(override_in), .motor_on(motor_on), .bin_in(bin_in),
    .nv_restore(16'h0011), .nv_out(nv_out), .main_setpoint(main_sp),
    .supp_setpoint(supp_sp), .updown_output_after_ramp(ud), .override_active(ovr_act));
  fieldbus_partner #(.PZD_WORDS(2)) i_fieldbus_partner (
    .pclk(pclk), .speed(bus_speed), .pins(pins), .pzd_rx(pzd_rx), .bin_in(bin_in));
  always @(negedge pclk) if (nv_out.write === 1'b1) begin
    nv_cnt++;
    nv_val = nv_out.value;
  end
  // ****************
  // access tasks
  // ****************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x, q)
  endtask : rdchk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : tick
  task automatic put(input logic [BIN_N-1:0] p, input logic m);
    @(posedge pclk);
    pins     <= p;
    motor_on <= m;
    tick(6);
  endtask : put
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
  // ****************
  // tests
  // ****************
  initial begin
    logic [31:0] q;
    logic        e;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rdchk(ra[i], rv[i], "reset value");
    apb(1'b0, 8'h34, 32'h0, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    for (int s = 0; s < 4; s++) begin
      wr(OFS_MAIN_SEL, s);
      wr(OFS_SUPP_SEL, 3 - s);
      tick(3);
      `CHK("main source", ex[s], main_sp)
      `CHK("supp source", ex[3-s], supp_sp)
    end
    wr(OFS_MAIN_SEL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      override_in <= '{i > 0, 16'h0111, i > 1, 16'h0222, i > 2, 16'h0333};
      tick(2);
      `CHK("main override", ovx[i], main_sp)
      `CHK("override flag", 1'(i > 0), ovr_act)
    end
    @(posedge pclk);
    override_in <= '0;
    wr(OFS_MAIN_SEL, 32'h2);
    wr(OFS_SRC, 32'h0000d8d1);
    wr(OFS_MAX, 32'h64);
    wr(OFS_MIN, 32'hffce);
    wr(OFS_START, 32'h14);
    wr(OFS_UP_T, 32'h32);
    wr(OFS_DN_T, 32'h32);
    wr(OFS_CFG, 32'h0);
    rdchk(OFS_CFG, 32'h0, "config rw");
    wr(OFS_CFG, 32'h1);
    put(7'h00, 1'b1);
    `CHK("nv restored", 16'h0011, ud)
    wr(OFS_CFG, 32'h0);
    put(7'h00, 1'b0);
    put(7'h00, 1'b1);
    `CHK("start value", 16'h0014, ud)
    `CHK("main updown", 16'h0014, main_sp)
    put(7'h09, 1'b1);
    `CHK("auto raise", 16'h0064, ud)
    put(7'h0a, 1'b1);
    `CHK("auto lower", 16'hffce, ud)
    put(7'h0b, 1'b1);
    `CHK("both held", 16'hffce, ud)
    put(7'h0d, 1'b1);
    `CHK("inverted max", 16'h0032, ud)
    put(7'h08, 1'b1);
    @(posedge pclk);
    analog_ch0 <= 16'h001e;
    put(7'h18, 1'b1);
    `CHK("preset load", 16'h001e, ud)
    rdchk(OFS_OUT, 32'h0000001e, "output read");
    put(7'h01, 1'b1);
    tick(94);
    `CHK("ramp mid", 1'b1, ud > 16'sd60 && ud < 16'sd95)
    tick(200);
    `CHK("ramp end", 16'h0064, ud)
    wr(OFS_CFG, 32'h09);
    put(7'h00, 1'b0);
    `CHK("store pulses", 1, nv_cnt)
    `CHK("store value", 16'h0064, nv_val)
    put(7'h10, 1'b0);
    `CHK("preset off", 16'h001e, ud)
    put(7'h00, 1'b1);
    `CHK("restored", 16'h0064, ud)
    wr(OFS_CFG, 32'h0);
    put(7'h00, 1'b0);
    put(7'h00, 1'b1);
    `CHK("no storage", 16'h0014, ud)
    wr(OFS_CFG, 32'h10);
    put(7'h0a, 1'b0);
    `CHK("ramp when off", 16'hffce, ud)
    wr(OFS_CFG, 32'h0);
    put(7'h09, 1'b0);
    `CHK("hold when off", 16'hffce, ud)
    put(7'h00, 1'b0);
    wr(OFS_CFG, 32'h04);
    put(7'h01, 1'b1);
    tick(94);
    `CHK("rounded ramp", 1'b1, ud > 16'sd25 && ud < 16'sd45)
    stop_test();
  end
endmodule : testbench
